// ===== ees_core.sv
// two-wire serial eeprom slave: bus engine, page latch, self-timed write
`timescale 1ns/1ns
// How it works
// - array of 32768 bytes, addressed by a fifteen-bit byte pointer.
// - 64-byte pages; only bytes received in a burst are programmed.
// - write cycle timed by the system clock alone, at most 5 ms.
// - during reset all bus activity ignored; release leaves machine in standby.
// - reset during a transaction abandons it, no write starts.
// - after stop, standby at once, or when a pending write completes.
// - write-protect high refuses every data byte received; low allows writes.
// - three chip-select inputs compared against slave address bits 3..1.
// - data line only pulled low or released, never driven high.
// - serial clock is only sampled, never driven or stretched.
// - transaction order: device byte, two address bytes, then data.
// - device byte upper nibble 1010, three select bits, then direction.
// - matching device byte, both address bytes and each data byte taken while write-protect is low acknowledged on ninth clock.
// - stop after a write starts programming; no response until done.
// - page write wraps within the page, only low six bits increment.
module ees_core #(
  parameter int WRITE_CYCLES = ees_pkg::WRITE_CYCLES_DF
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  input  wire logic chip_select_bit0,
  input  wire logic chip_select_bit1,
  input  wire logic chip_select_bit2,
  input  wire logic write_protect,
  output logic      standby,
  output logic      write_busy
);

  ees_pkg::ees_core_state_t q;
  ees_pkg::ees_core_state_t next_q;

  logic [7:0]                    mem [ees_pkg::MEM_BYTES];
  logic [7:0]                    page_buf [ees_pkg::PAGE_BYTES];
  logic                          buf_in_ready;
  logic                          buf_out_valid;
  logic                          latch_tick;
  ees_pkg::ees_page_word_t       buf_out_word;
  logic                          mem_we;
  logic [ees_pkg::ADDR_W-1:0]    mem_waddr;
  logic [7:0]                    mem_rdata;
  logic                          nscl;
  logic                          nsda;
  logic                          scl_rise;
  logic                          scl_fall;
  logic                          start_det;
  logic                          stop_det;
  logic                          dev_match;

  // glitch filter: a level is taken only when three samples agree
  function automatic logic filt(input logic [2:0] hist, input logic cur);
    if (hist == ees_pkg::FILT_ALL_HIGH) begin
      filt = 1'b1;
    end else if (hist == ees_pkg::FILT_ALL_LOW) begin
      filt = 1'b0;
    end else begin
      filt = cur;
    end
  endfunction : filt

  ees_buf2 u_buf (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (q.push),
    .in_ready  (buf_in_ready),
    .in_data   (q.push_word),
    .out_valid (buf_out_valid),
    .out_ready (latch_tick),
    .out_data  (buf_out_word)
  );

  assign latch_tick = (q.latch_div == ees_pkg::LATCH_DIV_LAST);
  assign nscl       = filt(q.scl_hist, q.scl_f);
  assign nsda       = filt(q.sda_hist, q.sda_f);
  assign scl_rise   = nscl & ~q.scl_f;
  assign scl_fall   = ~nscl & q.scl_f;
  assign start_det  = q.scl_f & nscl & q.sda_f & ~nsda;
  assign stop_det   = q.scl_f & nscl & ~q.sda_f & nsda;
  assign dev_match  = (q.shreg[7:4] == ees_pkg::DEV_TYPE) &&
                      (q.shreg[3:1] == {chip_select_bit2, chip_select_bit1, chip_select_bit0});
  assign mem_rdata  = mem[q.ptr];
  assign mem_waddr  = {q.wr_page, q.prog_cnt[ees_pkg::PAGE_W-1:0]};
  assign mem_we     = q.busy && (q.prog_cnt < ees_pkg::PROG_CNT_W'(ees_pkg::PAGE_BYTES)) &&
                      q.mask[q.prog_cnt[ees_pkg::PAGE_W-1:0]];

  always_comb begin
    next_q           = q;
    next_q.push      = 1'b0;
    next_q.sda_zero  = 1'b0;
    next_q.scl_sync  = {q.scl_sync[0], scl_in};
    next_q.sda_sync  = {q.sda_sync[0], sda_in};
    next_q.scl_hist  = {q.scl_hist[1:0], q.scl_sync[1]};
    next_q.sda_hist  = {q.sda_hist[1:0], q.sda_sync[1]};
    next_q.scl_f     = nscl;
    next_q.sda_f     = nsda;
    next_q.latch_div = q.latch_div + 2'h1;
    // page latch takes one buffered word per divider tick
    if (latch_tick && buf_out_valid) begin
      next_q.mask[buf_out_word.offset] = 1'b1;
    end
    // bus engine
    case (q.bus)
      ees_pkg::ST_IDLE: begin
        next_q.drive = 1'b0;
      end
      ees_pkg::ST_RX: begin
        if (scl_rise) begin
          next_q.shreg   = {q.shreg[6:0], nsda};
          next_q.bit_cnt = q.bit_cnt + 4'h1;
        end else if (scl_fall && q.bit_cnt == ees_pkg::BITS_PER_BYTE) begin
          next_q.bit_cnt = '0;
          next_q.bus     = ees_pkg::ST_ACK;
          next_q.drive   = 1'b1;
          case (q.byte_idx)
            ees_pkg::IDX_DEVSEL: begin
              next_q.rw = q.shreg[0];
              if (!dev_match) begin
                next_q.bus   = ees_pkg::ST_IDLE;
                next_q.drive = 1'b0;
              end
            end
            ees_pkg::IDX_ADDR_HI: begin
              next_q.ptr[ees_pkg::ADDR_W-1:8] = q.shreg[6:0];
            end
            ees_pkg::IDX_ADDR_LO: begin
              next_q.ptr[7:0] = q.shreg;
              // page number from the high byte just taken and the top bits of this byte
              next_q.wr_page  = {q.ptr[ees_pkg::ADDR_W-1:8], q.shreg[7:ees_pkg::PAGE_W]};
            end
            default: begin
              if (write_protect || !buf_in_ready) begin
                next_q.bus   = ees_pkg::ST_IDLE;
                next_q.drive = 1'b0;
              end else begin
                next_q.push           = 1'b1;
                next_q.push_word      = {q.ptr[ees_pkg::PAGE_W-1:0], q.shreg};
                next_q.ptr[ees_pkg::PAGE_W-1:0] = q.ptr[ees_pkg::PAGE_W-1:0] + 6'h01;
              end
            end
          endcase
          if (q.byte_idx != ees_pkg::IDX_DATA) begin
            next_q.byte_idx = q.byte_idx + 2'h1;
          end
        end
      end
      ees_pkg::ST_ACK: begin
        if (scl_fall) begin
          if (q.rw) begin
            next_q.bus   = ees_pkg::ST_TX;
            next_q.shreg = mem_rdata;
            next_q.drive = ~mem_rdata[7];
          end else begin
            next_q.bus   = ees_pkg::ST_RX;
            next_q.drive = 1'b0;
          end
        end
      end
      ees_pkg::ST_TX: begin
        if (scl_rise) begin
          next_q.bit_cnt = q.bit_cnt + 4'h1;
        end else if (scl_fall) begin
          if (q.bit_cnt == ees_pkg::BITS_PER_BYTE) begin
            next_q.bit_cnt = '0;
            next_q.drive   = 1'b0;
            next_q.bus     = ees_pkg::ST_MACK;
          end else begin
            next_q.shreg = {q.shreg[6:0], 1'b0};
            next_q.drive = ~q.shreg[6];
          end
        end
      end
      ees_pkg::ST_MACK: begin
        if (scl_rise) begin
          if (nsda) begin
            next_q.bus = ees_pkg::ST_IDLE;
          end else begin
            next_q.ptr = q.ptr + 15'h0001;
          end
        end else if (scl_fall) begin
          next_q.bus   = ees_pkg::ST_TX;
          next_q.shreg = mem_rdata;
          next_q.drive = ~mem_rdata[7];
        end
      end
      default: begin
        next_q.bus   = ees_pkg::ST_IDLE;
        next_q.drive = 1'b0;
      end
    endcase
    // start and stop override the bit engine
    if (start_det) begin
      next_q.drive    = 1'b0;
      next_q.bit_cnt  = '0;
      next_q.byte_idx = ees_pkg::IDX_DEVSEL;
      next_q.bus      = (q.busy || q.prog_req) ? ees_pkg::ST_IDLE : ees_pkg::ST_RX;
    end else if (stop_det) begin
      next_q.drive = 1'b0;
      next_q.bus   = ees_pkg::ST_IDLE;
      if (!q.rw && !q.busy && (q.mask != '0 || q.push || buf_out_valid)) begin
        next_q.prog_req = 1'b1;
      end
    end
    // self-timed write cycle starts once the latch has drained
    if (q.prog_req && !buf_out_valid && !q.push && !q.busy) begin
      next_q.prog_req = 1'b0;
      next_q.busy     = 1'b1;
      next_q.prog_cnt = '0;
    end
    if (q.busy) begin
      next_q.prog_cnt = q.prog_cnt + 20'h00001;
      if (q.prog_cnt == ees_pkg::PROG_CNT_W'(WRITE_CYCLES - 1)) begin
        next_q.busy = 1'b0;
        next_q.mask = '0;
      end
    end
    next_q.standby = (next_q.bus == ees_pkg::ST_IDLE) && !next_q.busy && !next_q.prog_req;
    next_q.oe_n    = ~next_q.drive;
  end

  // reset drops every transaction and pending write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q          <= '0;
      // lines idle high, so no false edge follows release
      q.scl_sync <= '1;
      q.sda_sync <= '1;
      q.scl_hist <= '1;
      q.sda_hist <= '1;
      q.scl_f    <= 1'b1;
      q.sda_f    <= 1'b1;
      q.oe_n     <= 1'b1;
      q.standby  <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= page_buf[q.prog_cnt[ees_pkg::PAGE_W-1:0]];
    end
    if (latch_tick && buf_out_valid) begin
      page_buf[buf_out_word.offset] <= buf_out_word.data;
    end
  end

  assign sda_out    = q.sda_zero;
  assign sda_oe_n   = q.oe_n;
  assign standby    = q.standby;
  assign write_busy = q.busy;

  sequence s_rx8;
    q.bus == ees_pkg::ST_RX && q.bit_cnt == ees_pkg::BITS_PER_BYTE && scl_fall && !start_det && !stop_det;
  endsequence

  sequence s_prog_start;
    !q.busy ##1 q.busy;
  endsequence

  property p_type_reject;
    @(posedge sys_clk) disable iff (!reset_n)
      s_rx8 and (q.byte_idx == ees_pkg::IDX_DEVSEL && q.shreg[7:4] != ees_pkg::DEV_TYPE) |=> q.bus == ees_pkg::ST_IDLE;
  endproperty
  a_type_reject: assert property (p_type_reject) else $error("foreign device type acknowledged");

  property p_select_reject;
    @(posedge sys_clk) disable iff (!reset_n)
      s_rx8 and (q.byte_idx == ees_pkg::IDX_DEVSEL &&
      q.shreg[3:1] != {chip_select_bit2, chip_select_bit1, chip_select_bit0}) |=> sda_oe_n;
  endproperty
  a_select_reject: assert property (p_select_reject) else $error("wrong chip select acknowledged");

  property p_ack_drive;
    @(posedge sys_clk) disable iff (!reset_n)
      s_rx8 and (q.byte_idx == ees_pkg::IDX_ADDR_HI) |=> !sda_oe_n && q.bus == ees_pkg::ST_ACK;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("address byte not acknowledged");

  property p_wp_refuse;
    @(posedge sys_clk) disable iff (!reset_n)
      q.push |-> !$past(write_protect);
  endproperty
  a_wp_refuse: assert property (p_wp_refuse) else $error("data byte taken while write protected");

  property p_busy_quiet;
    @(posedge sys_clk) disable iff (!reset_n)
      q.busy |-> sda_oe_n && q.bus == ees_pkg::ST_IDLE;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("bus answered during write cycle");

  property p_prog_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      s_prog_start |-> q.busy [*8] ##1 q.prog_cnt < ees_pkg::PROG_CNT_W'(WRITE_CYCLES);
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("write cycle length wrong");

  property p_page_fixed;
    @(posedge sys_clk) disable iff (!reset_n)
      q.push |-> q.ptr[ees_pkg::ADDR_W-1:ees_pkg::PAGE_W] == q.wr_page &&
      q.ptr[ees_pkg::PAGE_W-1:0] == q.push_word.offset + 6'h01;
  endproperty
  a_page_fixed: assert property (p_page_fixed) else $error("page pointer left its page");

  property p_masked_write;
    @(posedge sys_clk) disable iff (!reset_n)
      mem_we |-> q.busy && q.mask[q.prog_cnt[ees_pkg::PAGE_W-1:0]];
  endproperty
  a_masked_write: assert property (p_masked_write) else $error("unwritten page byte programmed");

  property p_standby_after;
    @(posedge sys_clk) disable iff (!reset_n)
      ($fell(q.busy) && q.bus == ees_pkg::ST_IDLE && !q.prog_req && !start_det) |=> standby;
  endproperty
  a_standby_after: assert property (p_standby_after) else $error("no standby after write cycle");

  property p_stop_starts;
    @(posedge sys_clk) disable iff (!reset_n)
      (stop_det && !q.rw && !q.busy && q.mask != '0) |=> q.prog_req ##[1:40] q.busy;
  endproperty
  a_stop_starts: assert property (p_stop_starts) else $error("stop did not start write cycle");

endmodule : ees_core

// ===== ees_pkg.sv
// shared constants and types for the serial eeprom slave core
package ees_pkg;

  localparam int          ADDR_W          = 15;
  localparam int          MEM_BYTES       = 32768;
  localparam int          PAGE_W          = 6;
  localparam int          PAGE_BYTES      = 64;
  localparam int          TOP_W           = ADDR_W - PAGE_W;
  localparam logic [3:0]  DEV_TYPE        = 4'ha;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [1:0]  IDX_DEVSEL      = 2'h0;
  localparam logic [1:0]  IDX_ADDR_HI     = 2'h1;
  localparam logic [1:0]  IDX_ADDR_LO     = 2'h2;
  localparam logic [1:0]  IDX_DATA        = 2'h3;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          WRITE_TIME_NS   = 5000000;
  // longest time: round down
  localparam int          WRITE_CYCLES_DF = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int          PROG_CNT_W      = 20;
  localparam logic [1:0]  LATCH_DIV_LAST  = 2'h3;
  localparam logic [2:0]  FILT_ALL_HIGH   = 3'h7;
  localparam logic [2:0]  FILT_ALL_LOW    = 3'h0;

  typedef struct packed {
    logic [PAGE_W-1:0] offset;
    logic [7:0]        data;
  } ees_page_word_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } ees_bus_state_t;

  typedef struct packed {
    ees_bus_state_t          bus;
    logic [1:0]              scl_sync;
    logic [1:0]              sda_sync;
    logic [2:0]              scl_hist;
    logic [2:0]              sda_hist;
    logic                    scl_f;
    logic                    sda_f;
    logic [3:0]              bit_cnt;
    logic [7:0]              shreg;
    logic [1:0]              byte_idx;
    logic                    rw;
    logic [ADDR_W-1:0]       ptr;
    logic [TOP_W-1:0]        wr_page;
    logic [PAGE_BYTES-1:0]   mask;
    logic                    prog_req;
    logic                    busy;
    logic [PROG_CNT_W-1:0]   prog_cnt;
    logic [1:0]              latch_div;
    logic                    drive;
    logic                    oe_n;
    logic                    sda_zero;
    logic                    standby;
    logic                    push;
    ees_page_word_t          push_word;
  } ees_core_state_t;

endpackage : ees_pkg

// ===== ees_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module ees_buf2 #(
  parameter int W = $bits(ees_pkg::ees_page_word_t)
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  typedef struct packed {
    logic [1:0][W-1:0] slot;
    logic              rd_ptr;
    logic              wr_ptr;
    logic [1:0]        count;
  } ees_buf_state_t;

  ees_buf_state_t q;
  ees_buf_state_t next_q;
  logic           do_push;
  logic           do_pop;

  assign in_ready  = (q.count != 2'h2);
  assign out_valid = (q.count != 2'h0);
  assign out_data  = q.slot[q.rd_ptr];
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  always_comb begin
    next_q = q;
    if (do_push) begin
      next_q.slot[q.wr_ptr] = in_data;
      next_q.wr_ptr         = ~q.wr_ptr;
    end
    if (do_pop) begin
      next_q.rd_ptr = ~q.rd_ptr;
    end
    case ({do_push, do_pop})
      2'b10:   next_q.count = q.count + 2'h1;
      2'b01:   next_q.count = q.count - 2'h1;
      default: next_q.count = q.count;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule : ees_buf2

// ===== ees_master_model.sv
// bus master model: makes clock, start and stop, drives data open-drain
`timescale 1ns/1ns
module ees_master_model (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_rel
);
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  // one third of a bit: ten system clocks
  task automatic q();
    repeat (10) @(negedge sys_clk);
  endtask : q

  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_rel = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask : start

  // stop: data rises while clock is high
  task automatic stop();
    sda_rel = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b1;
    q();
  endtask : stop

  // one clock pulse; data held a third of a bit on both sides of the edges
  task automatic bit_cycle(input logic d, output logic v);
    sda_rel = d;
    q();
    scl = 1'b1;
    q();
    v   = sda;
    scl = 1'b0;
    q();
  endtask : bit_cycle

  // eight bits msb first, then the acknowledge slot with the line released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], v);
    end
    bit_cycle(1'b1, v);
    ack = (v === 1'b0);
  endtask : send_byte

  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, v);
      b[i] = v;
    end
    bit_cycle(nack, v);
  endtask : recv_byte

  // two-cycle low pulse on the data line while the clock is high
  task automatic glitch();
    sda_rel = 1'b0;
    repeat (2) @(negedge sys_clk);
    sda_rel = 1'b1;
  endtask : glitch
endmodule : ees_master_model

// ===== tb_i2c_eeprom_slave_core.sv
// self-checking bench for the serial eeprom slave core
`timescale 1ns/1ns
module tb_i2c_eeprom_slave_core;
  localparam int WCYC = 600;
  typedef struct packed {
    logic [14:0] a;
    logic [7:0]  d;
  } ees_row_t;

  logic       sys_clk       = 1'b0;
  logic       reset_n       = 1'b0;
  logic       write_protect = 1'b0;
  logic [2:0] cs            = 3'h5;
  logic       scl;
  logic       sda_rel;
  logic       sda_out;
  logic       sda_oe_n;
  logic       standby;
  logic       write_busy;
  wire        sda           = sda_rel & (sda_oe_n | sda_out);
  int         mismatches    = 0;
  int         num_checks    = 0;
  logic [7:0] rd [$];
  ees_row_t   rows [4]      = '{'{15'h0000, 8'h5a}, '{15'h7fff, 8'ha5}, '{15'h1234, 8'h3c}, '{15'h4040, 8'hff}};

  always #5 sys_clk = ~sys_clk;

  ees_core #(.WRITE_CYCLES(WCYC)) dut (
    .sys_clk          (sys_clk),
    .reset_n          (reset_n),
    .scl_in           (scl),
    .sda_in           (sda),
    .sda_out          (sda_out),
    .sda_oe_n         (sda_oe_n),
    .chip_select_bit0 (cs[0]),
    .chip_select_bit1 (cs[1]),
    .chip_select_bit2 (cs[2]),
    .write_protect    (write_protect),
    .standby          (standby),
    .write_busy       (write_busy)
  );

  ees_master_model m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // device byte for writing, then both address bytes
  task automatic hdr(input logic [14:0] a, output logic ok);
    logic k1, k2, k3;
    m.start();
    m.send_byte({4'ha, cs, 1'b0}, k1);
    m.send_byte({1'b0, a[14:8]}, k2);
    m.send_byte(a[7:0], k3);
    ok = k1 & k2 & k3;
  endtask : hdr

  task automatic wr(input logic [14:0] a, input logic [7:0] d [$], output logic ok);
    logic k;
    hdr(a, ok);
    foreach (d[i]) begin
      m.send_byte(d[i], k);
      ok &= k;
    end
    m.stop();
  endtask : wr

  // random read of n bytes, last one not acknowledged
  task automatic rdq(input logic [14:0] a, input int n);
    logic       k;
    logic [7:0] b;
    hdr(a, k);
    chk(8'(k), 8'h1);
    m.start();
    m.send_byte({4'ha, cs, 1'b1}, k);
    chk(8'(k), 8'h1);
    rd = {};
    for (int i = 0; i < n; i++) begin
      m.recv_byte(i == n - 1, b);
      rd.push_back(b);
    end
    m.stop();
  endtask : rdq

  // follows one write cycle, polling the device while it programs
  task automatic wait_write();
    int   n;
    time  t0;
    logic k;
    n = 0;
    while (write_busy !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    t0 = $time;
    chk(8'(write_busy), 8'h1);
    chk(8'(standby), 8'h0);
    m.start();
    m.send_byte({4'ha, cs, 1'b0}, k);
    m.stop();
    chk(8'(k), 8'h0);
    n = 0;
    while (write_busy === 1'b1 && n < WCYC) begin
      @(negedge sys_clk);
      n++;
    end
    chk(8'(($time - t0) / 10 <= WCYC + 2), 8'h1);
    chk(8'(($time - t0) / 10 >= WCYC - 20), 8'h1);
    repeat (2) @(negedge sys_clk);
    chk(8'(standby), 8'h1);
  endtask : wait_write

  // the data line is only ever pulled low
  always @(negedge sys_clk) begin
    if (reset_n && sda_out !== 1'b0) begin
      mismatches++;
      $display("MISMATCH at %0t: data line driven high", $time);
    end
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    logic ok;
    logic ack;
    repeat (3) @(negedge sys_clk);
    chk(8'(sda_oe_n), 8'h1);
    chk(8'(standby), 8'h1);
    chk(8'(write_busy), 8'h0);
    repeat (7) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (20) @(negedge sys_clk);
    foreach (rows[i]) begin
      wr(rows[i].a, {rows[i].d}, ok);
      chk(8'(ok), 8'h1);
      wait_write();
      rdq(rows[i].a, 1);
      chk(rd[0], rows[i].d);
    end
    rdq(15'h7fff, 2);
    chk(rd[1], 8'h5a);
    repeat (20) @(negedge sys_clk);
    chk(8'(standby), 8'h1);
    m.glitch();
    for (int i = 0; i < 12; i++) begin
      @(negedge sys_clk);
      chk(8'(standby), 8'h1);
    end
    wr(15'h0101, {8'h77}, ok);
    wait_write();
    wr(15'h013e, {8'ha1, 8'hb2, 8'hc3}, ok);
    chk(8'(ok), 8'h1);
    wait_write();
    rdq(15'h0100, 2);
    chk(rd[0], 8'hc3);
    chk(rd[1], 8'h77);
    rdq(15'h013e, 2);
    chk(rd[0], 8'ha1);
    chk(rd[1], 8'hb2);
    write_protect = 1'b1;
    hdr(15'h1234, ok);
    m.send_byte(8'hee, ack);
    m.stop();
    chk(8'(ack), 8'h0);
    repeat (50) @(negedge sys_clk);
    chk(8'(write_busy), 8'h0);
    write_protect = 1'b0;
    rdq(15'h1234, 1);
    chk(rd[0], 8'h3c);
    for (int i = 0; i < 4; i++) begin
      m.start();
      m.send_byte(i < 3 ? {4'ha, cs ^ (3'h1 << i), 1'b1} : {4'he, cs, 1'b1}, ack);
      m.stop();
      chk(8'(ack), 8'h0);
    end
    cs = 3'h2;
    rdq(15'h0000, 1);
    chk(rd[0], 8'h5a);
    hdr(15'h0000, ok);
    m.send_byte(8'h99, ack);
    reset_n = 1'b0;
    @(negedge sys_clk);
    chk(8'(sda_oe_n), 8'h1);
    m.start();
    m.send_byte({4'ha, cs, 1'b0}, ack);
    chk(8'(ack), 8'h0);
    m.stop();
    reset_n = 1'b1;
    repeat (100) @(negedge sys_clk);
    chk(8'(write_busy), 8'h0);
    chk(8'(standby), 8'h1);
    rdq(15'h0000, 1);
    chk(rd[0], 8'h5a);
    end_of_test();
  end
endmodule : tb_i2c_eeprom_slave_core
